//--- shared/msc_pkg.sv
// Constants for the message interrupt capability registers
//
// How it works
// R1: The identifier byte always reads 05h and ignores every write.
// R2: The next item byte is read only and gives the next capability location.
// R3: As the last capability in the list the next item byte reads 00h.
// R4: Reset clears the enable bit, and while it is clear service goes via the legacy pin.
// R5: Writing one to bit 0 of the control word switches the function to message interrupts.
// R6: Only configuration software may change the writable control bits, never a driver.
// R7: The upper control byte reads zero and writes to it are dropped.
// R8: Bit 7 reads one when the function can produce a 64-bit message address.
// R9: Writes to bit 7 leave it unchanged.
// R10: Bits 6 to 4 give the granted count as a power of two, codes 110 and 111 reserved.
// R11: Software grants no more messages than the function requests.
// R12: Reset returns the granted count field to 000, one message.
// R13: Bits 3 to 1 are read only and give the requested count in the same code.
// R14: With message interrupts on, the legacy pin stays idle and only messages are sent; here a driven pin is released one clock after enable.
package msc_pkg;

  // Configuration byte address of this capability
  localparam logic [7:0]  CAP_BASE       = 8'h40;
  // Identifier and list link
  localparam logic [7:0]  IDENT_VALUE    = 8'h05;
  localparam logic [7:0]  NEXT_PTR_VALUE = 8'h00;
  // Byte lanes of the capability dword
  localparam int          ID_LSB         = 0;
  localparam int          NEXT_LSB       = 8;
  localparam int          CTRL_LSB       = 16;
  localparam int          CTRL_LANE      = 2;
  // Message control word fields
  localparam int          EN_BIT         = 0;
  localparam int          REQ_LSB        = 1;
  localparam int          ALLOC_LSB      = 4;
  localparam int          ADDR64_BIT     = 7;
  localparam int          RSVD_LSB       = 8;
  // Field reset and fixed values
  localparam logic        EN_RESET       = 1'b0;
  localparam logic [2:0]  ALLOC_RESET    = 3'b000;
  localparam logic [2:0]  REQ_VALUE      = 3'b010;
  localparam logic        ADDR64_VALUE   = 1'b1;
  localparam logic [7:0]  RSVD_VALUE     = 8'h00;
  // Lowest reserved count code
  localparam logic [2:0]  CODE_RSVD_MIN  = 3'b110;

  typedef enum logic [3:0] {
    MSC_IDLE     = 4'b0001,
    MSC_LEGACY   = 4'b0010,
    MSC_MSG_WAIT = 4'b0100,
    MSC_MSG_HOLD = 4'b1000
  } msc_state_type;

  // Mask of vector bits a count code lets the function vary
  function automatic logic [4:0] msc_count_mask(input logic [2:0] code);
    logic [5:0] span;
    span = 6'h01 << code;
    return 5'((span - 6'h01));
  endfunction : msc_count_mask

endpackage : msc_pkg

//--- shared/msc_ctrl_if.sv
// Carrier between the register front end and the message control word
`timescale 1ns/1ps
interface msc_ctrl_if;
  logic        wr_lo;
  logic [7:0]  wdata_lo;
  logic        enable;
  logic [2:0]  alloc;
  logic [15:0] word;

  modport owner (
    input  wr_lo,
    input  wdata_lo,
    output enable,
    output alloc,
    output word
  );

  modport user (
    output wr_lo,
    output wdata_lo,
    input  enable,
    input  alloc,
    input  word
  );
endinterface : msc_ctrl_if

//--- verilog/msc_ctrl_field.sv
// Message control word storage and read value
`timescale 1ns/1ps
module msc_ctrl_field #(
  parameter logic       ADDR64_CAP = msc_pkg::ADDR64_VALUE,
  parameter logic [2:0] REQ_CODE   = msc_pkg::REQ_VALUE
) (
  input wire logic     sys_clk,
  input wire logic     rst_n,
  msc_ctrl_if.owner    ctl
);

  logic       en_reg;
  logic       en_next;
  logic [2:0] alloc_reg;
  logic [2:0] alloc_next;
  logic [2:0] wr_code;

  always_comb begin
    en_next    = en_reg;
    alloc_next = alloc_reg;
    wr_code    = ctl.wdata_lo[msc_pkg::ALLOC_LSB +: 3];
    if (ctl.wr_lo) begin
      en_next = ctl.wdata_lo[msc_pkg::EN_BIT]; // [R5]
      // Reserved count codes are not stored
      if (wr_code < msc_pkg::CODE_RSVD_MIN) begin
        alloc_next = wr_code; // [R10]
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_reg    <= msc_pkg::EN_RESET; // [R4]
      alloc_reg <= msc_pkg::ALLOC_RESET; // [R12]
    end else begin
      en_reg    <= en_next;
      alloc_reg <= alloc_next;
    end
  end

  assign ctl.enable = en_reg;
  assign ctl.alloc  = alloc_reg;
  // Bits 7, 3:1 fixed and upper byte zero, so writes cannot reach them
  assign ctl.word   = {msc_pkg::RSVD_VALUE, // [R7]
                       ADDR64_CAP, // [R8] [R9]
                       alloc_reg,
                       REQ_CODE, // [R13]
                       en_reg};

endmodule : msc_ctrl_field

//--- verilog/msc_regs.sv
// Message interrupt capability registers with interrupt routing
`timescale 1ns/1ps
module msc_regs #(
  parameter logic [7:0] NEXT_PTR   = msc_pkg::NEXT_PTR_VALUE,
  parameter logic       ADDR64_CAP = msc_pkg::ADDR64_VALUE,
  parameter logic [2:0] REQ_CODE   = msc_pkg::REQ_VALUE
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        cfg_rd,
  input  wire logic        cfg_wr,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_ack,
  input  wire logic        irq_req,
  input  wire logic [4:0]  irq_vector,
  input  wire logic        msg_ack,
  output logic             msg_req,
  output logic      [4:0]  msg_vector,
  output logic             int_pin_out,
  output logic             int_pin_oe_n,
  output logic             msi_enabled,
  output logic      [2:0]  msg_alloc_code
);

  msc_ctrl_if ctl ();

  msc_ctrl_field #(
    .ADDR64_CAP (ADDR64_CAP),
    .REQ_CODE   (REQ_CODE)
  ) u_ctrl (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ctl     (ctl.owner)
  );

  // ------------------------------------------------------------
  // Configuration access front end
  // ------------------------------------------------------------

  logic        cap_hit;
  logic [31:0] cap_dword;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        ack_reg;
  logic        ack_next;

  // Only the one aligned dword of the capability is decoded
  assign cap_hit = (cfg_addr[7:2] == msc_pkg::CAP_BASE[7:2]);

  // Writes reach only the low control byte; other lanes are read only
  assign ctl.wr_lo    = cfg_wr && cap_hit && cfg_be[msc_pkg::CTRL_LANE]; // [R1] [R2] [R7]
  assign ctl.wdata_lo = cfg_wdata[msc_pkg::CTRL_LSB +: 8];

  always_comb begin
    cap_dword = 32'h0000_0000;
    cap_dword[msc_pkg::ID_LSB +: 8]    = msc_pkg::IDENT_VALUE; // [R1]
    cap_dword[msc_pkg::NEXT_LSB +: 8]  = NEXT_PTR; // [R2] [R3]
    cap_dword[msc_pkg::CTRL_LSB +: 16] = ctl.word;
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    ack_next   = 1'b0;
    if (cap_hit && (cfg_rd || cfg_wr)) begin
      ack_next = 1'b1;
    end
    if (cap_hit && cfg_rd) begin
      rdata_next = cap_dword;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
      ack_reg   <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      ack_reg   <= ack_next;
    end
  end

  assign cfg_rdata = rdata_reg;
  assign cfg_ack   = ack_reg;

  // ------------------------------------------------------------
  // Status copies of the control word
  // ------------------------------------------------------------

  logic       en_copy_reg;
  logic       en_copy_next;
  logic [2:0] alloc_copy_reg;
  logic [2:0] alloc_copy_next;

  always_comb begin
    en_copy_next    = ctl.enable;
    alloc_copy_next = ctl.alloc;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_copy_reg    <= msc_pkg::EN_RESET;
      alloc_copy_reg <= msc_pkg::ALLOC_RESET;
    end else begin
      en_copy_reg    <= en_copy_next;
      alloc_copy_reg <= alloc_copy_next;
    end
  end

  assign msi_enabled    = en_copy_reg;
  assign msg_alloc_code = alloc_copy_reg;

  // ------------------------------------------------------------
  // Interrupt delivery: legacy pin or message request
  // ------------------------------------------------------------

  msc_pkg::msc_state_type state_reg;
  msc_pkg::msc_state_type state_next;
  logic [4:0]             vec_reg;
  logic [4:0]             vec_next;
  logic                   pin_oe_n_reg;
  logic                   pin_oe_n_next;
  logic [4:0]             vec_mask;

  // Vector bits beyond the granted count are forced to zero
  assign vec_mask = msc_pkg::msc_count_mask(ctl.alloc); // [R10]

  always_comb begin
    state_next = state_reg;
    vec_next   = vec_reg;
    unique case (state_reg)
      msc_pkg::MSC_IDLE: begin
        if (irq_req) begin
          if (ctl.enable) begin
            // Message mode: the pin is never used
            state_next = msc_pkg::MSC_MSG_WAIT; // [R14]
            vec_next   = irq_vector & vec_mask;
          end else begin
            state_next = msc_pkg::MSC_LEGACY; // [R4]
          end
        end
      end
      msc_pkg::MSC_LEGACY: begin
        // Enabling messages releases the pin one clock after the enable bit sets
        if (!irq_req || ctl.enable) begin
          state_next = msc_pkg::MSC_IDLE; // [R14]
        end
      end
      msc_pkg::MSC_MSG_WAIT: begin
        // A write already requested runs to its end
        if (msg_ack) begin
          state_next = msc_pkg::MSC_MSG_HOLD;
        end
      end
      msc_pkg::MSC_MSG_HOLD: begin
        if (!irq_req) begin
          state_next = msc_pkg::MSC_IDLE;
        end else if (!ctl.enable) begin
          state_next = msc_pkg::MSC_LEGACY; // [R4]
        end
      end
      default: begin
        state_next = msc_pkg::MSC_IDLE;
      end
    endcase
    pin_oe_n_next = (state_next != msc_pkg::MSC_LEGACY);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= msc_pkg::MSC_IDLE;
      vec_reg      <= 5'h00;
      pin_oe_n_reg <= 1'b1;
    end else begin
      state_reg    <= state_next;
      vec_reg      <= vec_next;
      pin_oe_n_reg <= pin_oe_n_next;
    end
  end

  // Open-drain pin: only ever pulled low
  assign int_pin_out  = 1'b0;
  assign int_pin_oe_n = pin_oe_n_reg;
  assign msg_req      = state_reg[2];
  assign msg_vector   = vec_reg;

endmodule : msc_regs

//--- bench/msc_regs_asserts.sv
// Concurrent checks on the capability register ports
`timescale 1ns/1ps
module msc_regs_asserts #(
  parameter logic [2:0] REQ_CODE = 3'b010
) (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        cfg_rd,
  input wire logic        cfg_wr,
  input wire logic [7:0]  cfg_addr,
  input wire logic [3:0]  cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic        cfg_ack,
  input wire logic        irq_req,
  input wire logic [4:0]  irq_vector,
  input wire logic        msg_ack,
  input wire logic        msg_req,
  input wire logic [4:0]  msg_vector,
  input wire logic        int_pin_out,
  input wire logic        int_pin_oe_n,
  input wire logic        msi_enabled,
  input wire logic [2:0]  msg_alloc_code
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Answer to a read that had no write beside it
  sequence s_rd_done;
    cfg_ack && $past(cfg_rd && !cfg_wr);
  endsequence
  a_id_fixed:     assert property (s_rd_done |-> cfg_rdata[7:0] == 8'h05)
    else $error("identifier byte wrong");
  a_next_null:    assert property (s_rd_done |-> cfg_rdata[15:8] == 8'h00)
    else $error("next pointer not null");
  a_rsvd_zero:    assert property (s_rd_done |-> cfg_rdata[31:24] == 8'h00)
    else $error("reserved byte not zero");
  a_addr64_flag:  assert property (s_rd_done |-> cfg_rdata[23])
    else $error("address flag lost");
  a_req_code:     assert property (s_rd_done |-> cfg_rdata[19:17] == REQ_CODE)
    else $error("requested count wrong");
  a_enable_match: assert property (s_rd_done |-> cfg_rdata[16] == msi_enabled)
    else $error("enable bit and output differ");
  a_alloc_legal:  assert property (msi_enabled |-> msg_alloc_code < 3'b110)
    else $error("reserved count code stored");
  a_pin_quiet:    assert property (msi_enabled && $past(msi_enabled) |-> int_pin_oe_n)
    else $error("legacy pin driven with messages on");
  a_pin_release:  assert property ($rose(msi_enabled) |-> int_pin_oe_n)
    else $error("legacy pin held after enable");
  // Message write pending, and message write completed
  sequence s_msg_wait;
    msg_req && !msg_ack;
  endsequence
  sequence s_msg_taken;
    msg_req && msg_ack;
  endsequence
  a_msg_held:     assert property (s_msg_wait |=> msg_req)
    else $error("message request dropped early");
  a_msg_done:     assert property (s_msg_taken |=> !msg_req)
    else $error("message request not cleared");
endmodule : msc_regs_asserts

//--- bench/testbench.sv
// Self-checking bench for the capability registers
`timescale 1ns/1ps
module testbench;
  logic        sys_clk, rst_n, cfg_rd, cfg_wr, irq_req, msg_ack, ack;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, rd;
  logic [4:0]  irq_vector, msg_vector;
  logic [2:0]  msg_alloc_code;
  logic        cfg_ack, msg_req, int_pin_out, int_pin_oe_n, msi_enabled;
  int          fail_count = 0;
  int          n_tests = 0;

  // Requested count of 32 keeps every granted code within the request
  localparam logic [2:0] REQ_CODE = 3'b101;

  msc_regs #(.REQ_CODE(REQ_CODE)) msc_regs_i (.*);

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic access(input logic r, w, input logic [7:0] a, input logic [3:0] b,
                        input logic [31:0] d);
    @(posedge sys_clk);
    cfg_rd <= r;
    cfg_wr <= w;
    cfg_addr <= a;
    cfg_be <= b;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_rd <= 1'b0;
    cfg_wr <= 1'b0;
    #1;
    for (int i = 0; i < 3 && cfg_ack !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    ack = cfg_ack;
    rd = cfg_rdata;
  endtask : access

  task automatic ctrl_wr(input logic [7:0] c);
    access(1'b0, 1'b1, 8'h40, 4'b0100, {8'h00, c, 16'h0000});
    check("write ack", 32'h0000_0001, 32'(ack));
  endtask : ctrl_wr

  task automatic t_reset_view;
    access(1'b1, 1'b0, 8'h40, 4'h0, 32'h0000_0000);
    check("reset dword", 32'h008A_0005, rd);
    check("read ack", 32'h0000_0001, 32'(ack));
    check("pin idle", 32'h0000_0001, 32'(int_pin_oe_n));
    access(1'b1, 1'b0, 8'h44, 4'h0, 32'h0000_0000);
    check("unmapped", 32'h0000_0000, rd | 32'(ack));
  endtask : t_reset_view

  task automatic t_ro_writes;
    access(1'b0, 1'b1, 8'h40, 4'hF, 32'hFFFF_FFFF);
    access(1'b1, 1'b0, 8'h40, 4'h0, 32'h0000_0000);
    check("ro dword", 32'h008B_0005, rd);
    access(1'b0, 1'b1, 8'h40, 4'b1011, 32'h0000_0000);
    access(1'b1, 1'b0, 8'h40, 4'h0, 32'h0000_0000);
    check("lane gate", 32'h008B_0005, rd);
  endtask : t_ro_writes

  task automatic t_alloc_codes;
    for (int c = 0; c < 6; c++) begin
      ctrl_wr({1'b0, 3'(c), 4'h1});
      access(1'b1, 1'b0, 8'h40, 4'h0, 32'h0000_0000);
      check("alloc dword", 32'h008B_0005 | (32'(c) << 20), rd);
      check("alloc out", 32'(c), 32'(msg_alloc_code));
    end
    ctrl_wr(8'h61);
    access(1'b1, 1'b0, 8'h40, 4'h0, 32'h0000_0000);
    check("alloc reserved", 32'h00DB_0005, rd);
  endtask : t_alloc_codes

  task automatic t_mid_reset;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    check("reset copies", 32'h0000_0000, {28'h000_0000, msg_alloc_code, msi_enabled});
    access(1'b1, 1'b0, 8'h40, 4'h0, 32'h0000_0000);
    check("reset again", 32'h008A_0005, rd);
  endtask : t_mid_reset

  task automatic t_legacy;
    ctrl_wr(8'h00);
    @(posedge sys_clk);
    irq_req <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    check("pin low", 32'h0000_0000, {int_pin_oe_n, 30'h0000_0000, msg_req});
    @(posedge sys_clk);
    irq_req <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    check("pin free", 32'h0000_0001, 32'(int_pin_oe_n));
    @(posedge sys_clk);
    irq_req <= 1'b1;
    repeat (3) @(posedge sys_clk);
    ctrl_wr(8'h01);
    repeat (2) @(posedge sys_clk);
    #1;
    check("pin released", 32'h0000_0003, {30'h0000_0000, int_pin_oe_n, msg_req});
    @(posedge sys_clk);
    msg_ack <= 1'b1;
    @(posedge sys_clk);
    msg_ack <= 1'b0;
    irq_req <= 1'b0;
  endtask : t_legacy

  task automatic t_message(input logic [7:0] c, input logic [4:0] v, input logic [4:0] exp_v);
    ctrl_wr(c);
    @(posedge sys_clk);
    irq_vector <= v;
    irq_req <= 1'b1;
    #1;
    for (int i = 0; i < 5 && msg_req !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    check("msg req", 32'h0000_0001, 32'(msg_req));
    check("msg vector", 32'(exp_v), 32'(msg_vector));
    check("pin quiet", 32'h0000_0001, 32'(int_pin_oe_n));
    @(posedge sys_clk);
    msg_ack <= 1'b1;
    @(posedge sys_clk);
    msg_ack <= 1'b0;
    irq_req <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    check("msg done", 32'h0000_0000, 32'(msg_req));
  endtask : t_message

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial begin
    #200_000;
    fail_count++;
    print_verdict();
  end

  initial begin
    {rst_n, cfg_rd, cfg_wr, irq_req, msg_ack} = 5'h00;
    {cfg_addr, cfg_be, cfg_wdata, irq_vector} = 49'h0_0000_0000_0000;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset_view();
    t_ro_writes();
    t_alloc_codes();
    t_mid_reset();
    t_legacy();
    t_message(8'h11, 5'h07, 5'h01);
    t_message(8'h51, 5'h17, 5'h17);
    print_verdict();
  end
endmodule : testbench

bind msc_regs msc_regs_asserts #(.REQ_CODE(REQ_CODE)) msc_regs_asserts_i (.*);
